// ---- port_io_pkg.sv ----
/*
   port_io_pkg: register addresses, reset values, field positions and
   the request carrier shared by the port i/o block, its checker and the bench.
   Assumes an 8-bit special-register space with bit addressing where the
   bit address is the register address plus the bit number.
*/
`default_nettype none
package port_io_pkg;
   // ==========================================================
   // register addresses
   localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;
   localparam logic [7:0] ADDR_PORT2_DATA = 8'hA0;
   localparam logic [7:0] ADDR_PORT3_DATA = 8'hB0;
   localparam logic [7:0] ADDR_PORT0_MODE = 8'hA4;
   localparam logic [7:0] ADDR_PORT2_MODE = 8'hA6;
   localparam logic [7:0] ADDR_PORT3_MODE = 8'hA7;
   localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'hE2;

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_DATA = 8'hFF;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_GLOBAL_CTRL = 8'h40;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // ==========================================================
   // global control field positions
   localparam int GC_PULLUP_DISABLE = 7;
   localparam int GC_INPUT_ENABLE = 6;
   localparam int GC_CLOCK_OUT = 0;

   // ==========================================================
   // fixed special-signal pins of port 0
   localparam int PIN_CLOCK_OUT = 0;
   localparam int PIN_EXT_CLOCK = 3;
   localparam int PIN_UART_TX = 4;
   localparam int PIN_UART_RX = 5;

   // bit address: upper five bits select the register, low three the bit
   localparam int BIT_IDX_W = 3;

   // ==========================================================
   // one processor access per cycle
   typedef struct packed {
      logic rd;       // read strobe
      logic wr;       // write strobe
      logic bit_acc;  // addr is a bit address
      logic rmw;      // read is the first half of read-modify-write
      logic [7:0] addr;
      logic [7:0] wdata; // bit writes use wdata[0]
   } sfr_req_t;
endpackage
`default_nettype wire

// ---- port_io_sync.sv ----
/*
   port_io_sync: three-stage input filter for asynchronous pin levels.
   Assumes its inputs may change at any time relative to mclk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module port_io_sync #(
   parameter int WIDTH = 15
) (
   input wire logic mclk_i,              // system clock
   input wire logic reset_n_i,           // async reset, active low
   input wire logic [WIDTH-1:0] async_i, // raw pin levels
   output logic [WIDTH-1:0] sync_o       // filtered levels
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_sync;

   // ==========================================================
   // a change counts only once stages two and three agree
   assign next_sync = (~(stage2 ^ stage3) & stage3)
                    | ((stage2 ^ stage3) & sync_o);

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta <= '0;
         stage2 <= '0;
         stage3 <= '0;
         sync_o <= '0;
      end else begin
         meta <= async_i;
         stage2 <= meta;
         stage3 <= stage2;
         sync_o <= next_sync;
      end
   end
endmodule // port_io_sync
`default_nettype wire

// ---- port_io_block.sv ----
/*
   port_io_block: fifteen port pins (port 0, port 2, port 3) with output
   latches, per-pin output mode, weak pullups, a global input enable and
   the fixed port-0 special signals, reached over the special-register
   port. Assumes one request per cycle and pads that resolve the pin from
   pin_o / pin_oe_o / pullup_o.

// How it works
// - open-drain: latch 0 pulls low, else float
// - push-pull: latch level always actively driven
// - pullup only when enabled, open-drain, latch one
// - data read gives pins, zero without input enable
// - input enable off blocks every input path
// - read-modify-write reads the latch, not pins
// - data write stores latch, latch keeps driving
// - clock-out bit puts inverted clock on pin0
// - port0 pin4 drives uart transmit AND latch
// - external clock pin3, uart receive pin5, gated
// - global control resets 40h, bits 5-1 zero
// - data resets all ones, missing bits read zero
// - output mode registers reset to open-drain
// - data registers take byte and bit access
// - port3 mode holds only bit zero
*/
`timescale 1ns/100ps
`default_nettype none
module port_io_block
   import port_io_pkg::*;
#(
   parameter int P0_W = 8,     // port 0 pins
   parameter int P2_W = 6,     // port 2 pins
   parameter int P3_W = 1,     // port 3 pins
   parameter int EXTERNAL_INTERRUPT_INPUT_PIN = 0  // pin feeding the external interrupt
) (
   input wire logic mclk_i,                         // system clock
   input wire logic reset_n_i,                      // async reset
   input wire sfr_req_t sfr_req_i,                  // processor access
   output logic [7:0] sfr_rdata_o,                  // read data
   output logic sfr_rvalid_o,                       // read data valid
   input wire logic [P0_W+P2_W+P3_W-1:0] pin_i,     // pad levels
   output logic [P0_W+P2_W+P3_W-1:0] pin_o,         // pad drive value
   output logic [P0_W+P2_W+P3_W-1:0] pin_oe_o,      // pad drive enable
   output logic [P0_W+P2_W+P3_W-1:0] pullup_o,      // weak pullup on
   input wire logic uart_tx_i,                      // uart transmit
   output logic uart_rx_o,                          // uart receive
   output logic external_clock_input_o,             // external clock
   output logic external_interrupt_input_o          // interrupt pin
);
   localparam int NPIN = P0_W + P2_W + P3_W;

   // ==========================================================
   // parameter checks
   if (P0_W < PIN_UART_RX + 1 || P0_W > 8) begin : g_bad_p0
      $error("port 0 width must be 6 to 8");
   end
   if (P2_W < 1 || P2_W > 8 || P3_W < 1 || P3_W > 8) begin : g_bad_p23
      $error("port 2 and port 3 widths must be 1 to 8");
   end
   if (EXTERNAL_INTERRUPT_INPUT_PIN < 0 || EXTERNAL_INTERRUPT_INPUT_PIN >= NPIN) begin : g_bad_int
      $error("interrupt pin out of range");
   end

   // ==========================================================
   // helpers
   // register content to a byte, unimplemented bits reading zero
   function automatic logic [7:0] widen(input logic [7:0] v,
                                        input int w);
      logic [7:0] mask;
      mask = 8'hFF >> (8 - w);
      return v & mask;
   endfunction

   // byte with one bit replaced, used by every bit write
   function automatic logic [7:0] put_bit(input logic [7:0] v,
                                          input logic [2:0] idx,
                                          input logic b);
      logic [7:0] r;
      r = v;
      r[idx] = b;
      return r;
   endfunction

   // ==========================================================
   // registers
   logic [P0_W-1:0] port_zero_data;
   logic [P2_W-1:0] port_two_data;
   logic [P3_W-1:0] port_three_data;
   logic [P0_W-1:0] port0_output_mode;
   logic [P2_W-1:0] port2_output_mode;
   logic port3_output_mode;
   logic pullup_disable;
   logic global_input_enable;
   logic clock_out_enable;
   logic [NPIN-1:0] pin_sync;
   logic [NPIN-1:0] drive_q;
   logic [NPIN-1:0] oe_q;

   // ==========================================================
   // pin input filter
   port_io_sync #(
      .WIDTH(NPIN)
   ) u_sync (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .async_i(pin_i),
      .sync_o(pin_sync)
   );

   // ==========================================================
   // gated input path: nothing reaches the core while inputs are off
   wire [NPIN-1:0] pin_gated = global_input_enable ? pin_sync
                                                   : '0;

   // ==========================================================
   // address decode
   wire req_byte = !sfr_req_i.bit_acc;
   wire [4:0] bit_reg = sfr_req_i.addr[7:BIT_IDX_W];
   wire [2:0] bit_idx = sfr_req_i.addr[BIT_IDX_W-1:0];
   wire hit_p0 = req_byte && sfr_req_i.addr == ADDR_PORT0_DATA;
   wire hit_p2 = req_byte && sfr_req_i.addr == ADDR_PORT2_DATA;
   wire hit_p3 = req_byte && sfr_req_i.addr == ADDR_PORT3_DATA;
   wire hit_m0 = req_byte && sfr_req_i.addr == ADDR_PORT0_MODE;
   wire hit_m2 = req_byte && sfr_req_i.addr == ADDR_PORT2_MODE;
   wire hit_m3 = req_byte && sfr_req_i.addr == ADDR_PORT3_MODE;
   wire hit_gc = req_byte && sfr_req_i.addr == ADDR_GLOBAL_CTRL;
   // bit addresses exist only for the three data registers
   wire bhit_p0 = sfr_req_i.bit_acc
                  && bit_reg == ADDR_PORT0_DATA[7:BIT_IDX_W];
   wire bhit_p2 = sfr_req_i.bit_acc
                  && bit_reg == ADDR_PORT2_DATA[7:BIT_IDX_W];
   wire bhit_p3 = sfr_req_i.bit_acc
                  && bit_reg == ADDR_PORT3_DATA[7:BIT_IDX_W];

   // ==========================================================
   // read sources: latch for read-modify-write, else gated pins
   wire [7:0] lat_p0 = widen(8'(port_zero_data), P0_W);
   wire [7:0] lat_p2 = widen(8'(port_two_data), P2_W);
   wire [7:0] lat_p3 = widen(8'(port_three_data), P3_W);
   wire [7:0] pin_p0 = widen(8'(pin_gated[P0_W-1:0]), P0_W);
   wire [7:0] pin_p2 = widen(8'(pin_gated[P0_W+P2_W-1:P0_W]),
                             P2_W);
   wire [7:0] pin_p3 = widen(8'(pin_gated[NPIN-1:P0_W+P2_W]),
                             P3_W);
   wire [7:0] src_p0 = sfr_req_i.rmw ? lat_p0 : pin_p0;
   wire [7:0] src_p2 = sfr_req_i.rmw ? lat_p2 : pin_p2;
   wire [7:0] src_p3 = sfr_req_i.rmw ? lat_p3 : pin_p3;
   wire [7:0] gc_read = {pullup_disable, global_input_enable,
                         5'h00, clock_out_enable};

   // byte read mux; unmapped addresses read zero
   wire [7:0] byte_read =
        hit_p0 ? src_p0
      : hit_p2 ? src_p2
      : hit_p3 ? src_p3
      : hit_m0 ? widen(8'(port0_output_mode), P0_W)
      : hit_m2 ? widen(8'(port2_output_mode), P2_W)
      : hit_m3 ? {7'h00, port3_output_mode}
      : hit_gc ? gc_read
      : ZERO_BYTE;

   // bit read returns the addressed bit in bit 0
   wire bit_read =
        bhit_p0 ? src_p0[bit_idx]
      : bhit_p2 ? src_p2[bit_idx]
      : bhit_p3 ? src_p3[bit_idx]
      : 1'b0;

   wire [7:0] next_rdata = sfr_req_i.bit_acc ? {7'h00, bit_read}
                                              : byte_read;

   // ==========================================================
   // write decode; a bit write is itself read-modify-write of the
   // latch, so the untouched bits keep the latch and not the pins
   wire wr_byte = sfr_req_i.wr && req_byte;
   wire wr_bit = sfr_req_i.wr && sfr_req_i.bit_acc;
   wire b_val = sfr_req_i.wdata[0];
   wire [7:0] next_p0 =
        (wr_byte && hit_p0) ? sfr_req_i.wdata
      : (wr_bit && bhit_p0) ? put_bit(lat_p0, bit_idx, b_val)
      : lat_p0;
   wire [7:0] next_p2 =
        (wr_byte && hit_p2) ? sfr_req_i.wdata
      : (wr_bit && bhit_p2) ? put_bit(lat_p2, bit_idx, b_val)
      : lat_p2;
   wire [7:0] next_p3 =
        (wr_byte && hit_p3) ? sfr_req_i.wdata
      : (wr_bit && bhit_p3) ? put_bit(lat_p3, bit_idx, b_val)
      : lat_p3;

   // ==========================================================
   // data latches, updated at the edge after the write
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         port_zero_data <= RST_DATA[P0_W-1:0];
         port_two_data <= RST_DATA[P2_W-1:0];
         port_three_data <= RST_DATA[P3_W-1:0];
      end else begin
         port_zero_data <= next_p0[P0_W-1:0];
         port_two_data <= next_p2[P2_W-1:0];
         port_three_data <= next_p3[P3_W-1:0];
      end
   end

   // mode and global control; unimplemented bits are simply not stored
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         port0_output_mode <= RST_MODE[P0_W-1:0];
         port2_output_mode <= RST_MODE[P2_W-1:0];
         port3_output_mode <= RST_MODE[0];
         pullup_disable <= RST_GLOBAL_CTRL[GC_PULLUP_DISABLE];
         global_input_enable <= RST_GLOBAL_CTRL[GC_INPUT_ENABLE];
         clock_out_enable <= RST_GLOBAL_CTRL[GC_CLOCK_OUT];
      end else begin
         if (wr_byte && hit_m0) begin
            port0_output_mode <= sfr_req_i.wdata[P0_W-1:0];
         end
         if (wr_byte && hit_m2) begin
            port2_output_mode <= sfr_req_i.wdata[P2_W-1:0];
         end
         if (wr_byte && hit_m3) begin
            port3_output_mode <= sfr_req_i.wdata[0];
         end
         if (wr_byte && hit_gc) begin
            pullup_disable <= sfr_req_i.wdata[GC_PULLUP_DISABLE];
            global_input_enable <= sfr_req_i.wdata[GC_INPUT_ENABLE];
            clock_out_enable <= sfr_req_i.wdata[GC_CLOCK_OUT];
         end
      end
   end

   // ==========================================================
   // read answer, one cycle after the strobe
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sfr_rdata_o <= ZERO_BYTE;
         sfr_rvalid_o <= 1'b0;
      end else begin
         sfr_rvalid_o <= sfr_req_i.rd;
         if (sfr_req_i.rd) begin
            sfr_rdata_o <= next_rdata;
         end
      end
   end

   // ==========================================================
   // pin drive: flat latch and mode vectors
   wire [NPIN-1:0] latch_all = {port_three_data, port_two_data,
                                port_zero_data};
   wire [NPIN-1:0] mode_all;
   assign mode_all[NPIN-1:P0_W] = {{P3_W{port3_output_mode}},
                                   port2_output_mode};
   assign mode_all[P0_W-1:0] = port0_output_mode;

   // transmit gated by its latch; a zero latch forces the line low
   wire [NPIN-1:0] value_all;
   assign value_all = latch_all
                    & ~(NPIN'(!uart_tx_i) << PIN_UART_TX);

   // open-drain drives only low; push-pull always drives
   wire [NPIN-1:0] next_oe = mode_all | ~value_all;
   // pullup needs enabled pullups, open-drain and a one latch
   wire [NPIN-1:0] next_pullup = {NPIN{!pullup_disable}}
                                 & ~mode_all & latch_all;

   // value, enable and pullup switch on one edge, so on every pin but pins 0 and 4
   // (pin 0's enable follows the mode at once, pin 4's follows transmit) a mode
   // change never shows a pullup on a pad that is already driven
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         drive_q <= '1;
         oe_q <= '0;
         pullup_o <= '0;
      end else begin
         drive_q <= value_all;
         oe_q <= next_oe;
         pullup_o <= next_pullup;
      end
   end

   // the clock output cannot come from a flop on the same clock, so
   // pin 0 is the one combinational pad path; its enable still follows
   // the open-drain or push-pull choice for that pin
   wire clk_pin_val = clock_out_enable ? ~mclk_i
                                       : drive_q[PIN_CLOCK_OUT];
   always_comb begin
      pin_o = drive_q;
      pin_oe_o = oe_q;
      pin_o[PIN_CLOCK_OUT] = clk_pin_val;
      pin_oe_o[PIN_CLOCK_OUT] = mode_all[PIN_CLOCK_OUT]
                                | ~clk_pin_val;
   end

   // ==========================================================
   // special inputs come only through the gated path
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         uart_rx_o <= 1'b0;
         external_clock_input_o <= 1'b0;
         external_interrupt_input_o <= 1'b0;
      end else begin
         uart_rx_o <= pin_gated[PIN_UART_RX];
         external_clock_input_o <= pin_gated[PIN_EXT_CLOCK];
         external_interrupt_input_o <= pin_gated[EXTERNAL_INTERRUPT_INPUT_PIN];
      end
   end
endmodule // port_io_block
`default_nettype wire

// ---- port_pads.sv ----
/*
   port_pads: outside circuits on the fifteen port pads.
   Assumes the bench sets which outside drivers are on and their levels.
*/
`timescale 1ns/100ps
`default_nettype none
module port_pads (
   input wire logic mclk_i,            // system clock
   input wire logic [14:0] drive_i,    // device drive value
   input wire logic [14:0] drive_en_i, // device drive enable
   input wire logic [14:0] pullup_i,   // device weak pullup
   input wire logic [14:0] ext_en_i,   // outside driver on
   input wire logic [14:0] ext_val_i,  // outside driver level
   output logic [14:0] level_o         // resolved pad level
);
   // =========================================================
   // pad resolution
   // a bare pad wanders so that a stale level is never read as valid
   logic [14:0] wander = 15'h5555;
   always @(posedge mclk_i) begin
      wander <= ~wander;
   end
   // device drive wins, then the outside circuit, then the pullup
   always_comb begin
      for (int i = 0; i < 15; i++) begin
         if (drive_en_i[i]) level_o[i] = drive_i[i];
         else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
         else if (pullup_i[i]) level_o[i] = 1'h1;
         else level_o[i] = wander[i];
      end
   end
endmodule // port_pads
`default_nettype wire

// ---- port_io_checker.sv ----
/*
   port_io_checker: timing relations at the port block's pins.
   Assumes default port widths: 8, 6 and 1 pins.
*/
`timescale 1ns/100ps
`default_nettype none
module port_io_checker
   import port_io_pkg::*;
#(
   parameter int PIN_W = 15
) (
   input wire logic mclk_i,                  // clock
   input wire logic reset_n_i,               // reset
   input wire sfr_req_t sfr_req_i,           // access
   input wire logic [7:0] sfr_rdata_o,       // read data
   input wire logic sfr_rvalid_o,            // read valid
   input wire logic [PIN_W-1:0] pin_i,       // pad level
   input wire logic [PIN_W-1:0] pin_o,       // drive value
   input wire logic [PIN_W-1:0] pin_oe_o,    // drive enable
   input wire logic [PIN_W-1:0] pullup_o,    // pullup
   input wire logic uart_tx_i,               // transmit
   input wire logic uart_rx_o                // receive
);
   // =========================================================
   // relations
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   a_float_is_high: assert property ((~pin_oe_o & ~pin_o) == '0)
      else $error("pad undriven while value low");
   // bits 0 and 4 may carry a special signal under a raised latch
   a_pullup_undriven: assert property
      ((pullup_o & pin_oe_o & 15'h7FEE) == '0)
      else $error("pullup on a driven pad");
   a_rvalid_follows: assert property (sfr_req_i.rd |=> sfr_rvalid_o)
      else $error("read not answered");
   a_rvalid_single: assert property
      (!sfr_req_i.rd |=> !sfr_rvalid_o)
      else $error("read valid without read");
   a_rdata_holds: assert property
      (!sfr_req_i.rd |=> $stable(sfr_rdata_o))
      else $error("read data moved without read");
   a_rx_from_pin: assert property
      (!pin_i[PIN_UART_RX] [*8] |-> !uart_rx_o)
      else $error("receive high with pin low");
   a_tx_gates_pin: assert property
      (!uart_tx_i [*2] |-> !pin_o[PIN_UART_TX])
      else $error("transmit low not on pin");
   a_p2_write: assert property
      (sfr_req_i.wr && !sfr_req_i.bit_acc && sfr_req_i.addr == ADDR_PORT2_DATA
       |-> ##2 pin_o[13:8] == $past(sfr_req_i.wdata[5:0], 2))
      else $error("port 2 write not on pins");
endmodule // port_io_checker
bind port_io_block port_io_checker #(.PIN_W(P0_W + P2_W + P3_W)) chk (
   .mclk_i(mclk_i), .reset_n_i(reset_n_i), .sfr_req_i(sfr_req_i),
   .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o), .pin_i(pin_i),
   .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o),
   .uart_tx_i(uart_tx_i), .uart_rx_o(uart_rx_o));
`default_nettype wire

// ---- tb_top.sv ----
/*
   tb_top: port block against a bench model, random writes and reads.
   Assumes port_pads for the pads and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   fail_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   import port_io_pkg::*;
   localparam logic [7:0] DA [3] = '{8'h80, 8'hA0, 8'hB0};
   localparam logic [7:0] MA [3] = '{8'hA4, 8'hA6, 8'hA7};
   localparam logic [7:0] MSK [3] = '{8'hFF, 8'h3F, 8'h01};
   localparam logic [7:0] RA [8] = '{8'h80, 8'hA0, 8'hB0, 8'hA4, 8'hA6,
      8'hA7, 8'hE2, 8'h90};
   logic mclk_i = 1'h0;
   logic reset_n_i = 1'h0;
   sfr_req_t req = '0;
   logic [7:0] rdata;
   logic rvalid, rx, xc, it;
   logic tx = 1'h1;
   logic [14:0] lvl, po, poe, pu;
   logic [14:0] ext_en = '0;
   logic [14:0] ext_val = '0;
   logic [31:0] r = '0;
   logic [7:0] lat [3];
   logic [7:0] md [3];
   logic [7:0] gc;
   int fail_count = 0;
   int checks_done = 0;
   int seed = 32'hbeccfe51;
   // =========================================================
   // clock, design and pads
   always #10 mclk_i = ~mclk_i;
   port_io_block uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .sfr_req_i(req), .sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid),
      .pin_i(lvl), .pin_o(po), .pin_oe_o(poe), .pullup_o(pu),
      .uart_tx_i(tx), .uart_rx_o(rx), .external_clock_input_o(xc),
      .external_interrupt_input_o(it));
   port_pads pads (.mclk_i(mclk_i), .drive_i(po), .drive_en_i(poe),
      .pullup_i(pu), .ext_en_i(ext_en), .ext_val_i(ext_val),
      .level_o(lvl));
   // =========================================================
   // tasks
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #2;
   endtask
   // write strobe, idle cycle, then the model follows
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic b);
      req = '{1'h0, 1'h1, b, 1'h0, a, d};
      cyc(1);
      req = '0;
      cyc(1);
      for (int k = 0; k < 3; k++) begin
         if (!b && a == DA[k]) lat[k] = d & MSK[k];
         if (!b && a == MA[k]) md[k] = d & MSK[k];
         if (b && a[7:3] == DA[k][7:3]) lat[k][a[2:0]] = d[0] & MSK[k][a[2:0]];
      end
      if (!b && a == 8'hE2) gc = d & 8'hC1;
   endtask
   task automatic rd(input logic [7:0] a, input logic m, input logic b,
                     output logic [7:0] d);
      int n;
      n = 0;
      req = '{1'h1, 1'h0, b, m, a, 8'h00};
      cyc(1);
      req = '0;
      while (rvalid !== 1'h1) begin
         if (n++ > 3) begin
            fail_count++;
            end_sim();
         end
         cyc(1);
      end
      d = rdata;
      cyc(1);
   endtask
   // every pad as the model sees it; a bare pad is unknown
   task automatic model_pins(output logic [14:0] o, oe, p, lv);
      int k;
      int b;
      for (int i = 0; i < 15; i++) begin
         k = (i < 8) ? 0 : (i < 14) ? 1 : 2;
         b = (i < 8) ? i : (i < 14) ? i - 8 : 0;
         o[i] = (i == 4) ? lat[k][b] & tx : lat[k][b];
         oe[i] = md[k][b] | !o[i];
         p[i] = !gc[7] & !md[k][b] & lat[k][b];
         lv[i] = oe[i] ? o[i] : ext_en[i] ? ext_val[i] : p[i] ? 1'h1 : 1'hx;
      end
   endtask
   function automatic logic [7:0] exp_rd(logic [7:0] a, logic m,
                                         logic [14:0] lv);
      logic [7:0] pv [3];
      logic [7:0] v;
      pv = '{lv[7:0], {2'h0, lv[13:8]}, {7'h00, lv[14]}};
      v = 8'h00;
      for (int k = 0; k < 3; k++) begin
         if (a == DA[k]) v = m ? lat[k] : gc[6] ? pv[k] : 8'h00;
         if (a == MA[k]) v = md[k];
      end
      if (a == 8'hE2) v = gc;
      return v;
   endfunction
   // pads and specials, then every register plain and read-modify-write
   task automatic check_all();
      logic [14:0] o, oe, p, lv, cm;
      logic [7:0] d, m8, e8;
      logic [2:0] bi;
      model_pins(o, oe, p, lv);
      cm = gc[0] ? 15'h7FFE : 15'h7FFF;
      `CHK(po & cm, o & cm)
      `CHK(poe & cm, oe & cm)
      `CHK(pu, p)
      `CHK(po[0], gc[0] ? 1'h0 : lat[0][0])
      `CHK(rx, gc[6] & lv[5])
      `CHK(xc, gc[6] & lv[3])
      if (!gc[0]) `CHK(it, gc[6] & lv[0])
      for (int i = 0; i < 16; i++) begin
         rd(RA[i / 2], i[0], 1'h0, d);
         m8 = (i == 0 && gc[0]) ? 8'hFE : 8'hFF;
         `CHK(d & m8, exp_rd(RA[i / 2], i[0], lv) & m8)
      end
      // one bit read per data register, bit and source from r
      for (int k = 0; k < 3; k++) begin
         bi = 3'(r[2:0] + k);
         rd(DA[k] | {5'h00, bi}, r[k], 1'h1, d);
         e8 = exp_rd(DA[k], r[k], lv);
         m8 = (k == 0 && bi == 3'h0 && gc[0] && !r[k]) ? 8'h00 : 8'h01;
         `CHK(d & m8, {7'h00, e8[bi]} & m8)
      end
   endtask
   // =========================================================
   // sequence
   initial begin
      #500000;
      fail_count++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge mclk_i);
      #2;
      reset_n_i = 1'h1;
      lat = MSK;
      md = '{8'h00, 8'h00, 8'h00};
      gc = 8'h40;
      // pullups rise one edge after release, then the pin filter
      cyc(8);
      check_all();
      ext_val = 15'h2A55;
      ext_en = 15'h7FFF;
      // modes and latches first, global enable last
      wr(8'hA6, 8'h0F, 1'h0);
      wr(8'h80, 8'hF0, 1'h0);
      wr(8'hE2, 8'h40, 1'h0);
      cyc(6);
      check_all();
      for (int i = 0; i < 60; i++) begin
         r = $random(seed);
         ext_val = r[14:0];
         tx = r[15];
         r = $random(seed);
         if (r[3]) wr(RA[r[2:0]], r[15:8], 1'h0);
         else wr(DA[r[5:4] % 3] | {5'h00, r[2:0]}, {7'h00, r[8]}, 1'h1);
         cyc(6);
         check_all();
      end
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
